// File: battery_protection_config_irq_bench.sv
// Self-checking bench for the protection threshold, deep under-voltage and interrupt register bank
module battery_protection_config_irq_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import bp_cfg_pkg::*;
    logic ref_clk_in, rst_in, wr_in, rd_in, slow_osc_in, irq_out;
    logic [11:0] addr_in;
    logic [7:0] wdata_in, rdata_out, last_rd;
    logic [5:0] ev;
    logic [7:0] code_o [4];
    logic [4:0] idx_o [4];
    logic [1:0] dly_o;
    logic [3:0] lvl_o;
    logic rd_seen;
    int err_total, num_checks, k, k2;
    logic [7:0] prev [4];
    logic [3:0] v;
    typedef struct {string name; logic [7:0] exp; logic [7:0] mask;} note_t;
    note_t notes [$];
    note_t n;
    bp_cfg_regs uut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .slow_osc_in(slow_osc_in),
        .uv_warning_in(ev[5]), .short_event_in(ev[4]), .dis_oc_event_in(ev[3]), .chg_oc_event_in(ev[2]),
        .dis_hc_event_in(ev[1]), .chg_hc_event_in(ev[0]), .dis_oc_threshold_code_out(code_o[0]),
        .chg_oc_threshold_code_out(code_o[1]), .dis_hc_threshold_code_out(code_o[2]),
        .chg_hc_threshold_code_out(code_o[3]), .dis_oc_index_out(idx_o[0]), .chg_oc_index_out(idx_o[1]),
        .dis_hc_index_out(idx_o[2]), .chg_hc_index_out(idx_o[3]), .undervoltage_delay_sel_out(dly_o),
        .undervoltage_level_sel_out(lvl_o), .irq_out(irq_out));
    initial begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end
    // Slow clock period chosen unrelated to the CPU clock
    initial begin
        slow_osc_in = 1'b0;
        forever #67.3 slow_osc_in = ~slow_osc_in;
    end
    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic complete_run();
        if (err_total == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic wr(logic [11:0] a, logic [7:0] d);
        @(posedge ref_clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge ref_clk_in);
        wr_in <= 1'b0;
    endtask
    // Mask zero means the read only fetches a value for the bench
    task automatic rd(logic [11:0] a, logic [7:0] e, string name, logic [7:0] m = 8'hff);
        notes.push_back('{name, e, m});
        @(posedge ref_clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge ref_clk_in);
        rd_in <= 1'b0;
        @(negedge ref_clk_in);
        #1;
    endtask
    always @(posedge ref_clk_in) rd_seen <= rd_in;
    always @(negedge ref_clk_in) begin
        if (rd_seen && notes.size() > 0) begin
            n = notes.pop_front();
            last_rd = rdata_out;
            if (n.mask != 8'h00) check(n.name, rdata_out, n.exp);
        end
    end
    // Poll the busy bits; a guard that never ends is a failure
    task automatic wait_idle();
        for (int i = 0; i < 300; i++) begin
            rd(OFS_STATUS, 8'h00, "status", 8'h00);
            if (last_rd[3:0] === 4'h0) return;
        end
        err_total++;
        complete_run();
    endtask
    initial begin
        rst_in = 1'b1;
        wr_in = 1'b0;
        rd_in = 1'b0;
        addr_in = 12'h000;
        wdata_in = 8'h00;
        ev = 6'h00;
        err_total = 0;
        num_checks = 0;
        void'($urandom(20));
        repeat (10) @(posedge ref_clk_in);
        rst_in <= 1'b0;
        rd(OFS_DEEP_UV, RST_DEEP_UV, "deep_uv reset");
        rd(OFS_IRQ_EN, RST_IRQ_EN, "irq_enable reset");
        rd(OFS_IRQ_FLAGS, RST_IRQ_FLAGS, "irq_flags reset");
        for (int i = 0; i < 4; i++) rd(OFS_DIS_OC + 12'(i), RST_LEVEL, "level reset");
        for (int d = 0; d < 4; d++) begin
            v = 4'($urandom);
            wr(OFS_DEEP_UV, {2'b11, 2'(d), v});
            rd(OFS_DEEP_UV, {2'b00, 2'(d), v}, "deep_uv");
            check("delay_sel", {6'h00, dly_o}, 8'(d));
            check("level_sel", {4'h0, lvl_o}, {4'h0, v});
        end
        wr(OFS_IRQ_EN, 8'hff);
        rd(OFS_IRQ_EN, 8'h3f, "irq_enable");
        for (int i = 0; i < 4; i++) begin
            k = (i == 3) ? NUM_CODES - 1 : int'($urandom % NUM_CODES);
            k2 = (k + 1) % NUM_CODES;
            prev[i] = CODE_TABLE[k];
            wr(OFS_DIS_OC + 12'(i), CODE_TABLE[k]);
            // Second write lands inside the guard window and must be lost
            wr(OFS_DIS_OC + 12'(i), CODE_TABLE[k2]);
            wait_idle();
            rd(OFS_DIS_OC + 12'(i), CODE_TABLE[k], "level guard");
            repeat (3) @(posedge ref_clk_in);
            check("code_out", code_o[i], CODE_TABLE[k]);
            check("index_out", {3'h0, idx_o[i]}, 8'(k));
        end
        for (int b = 0; b < 6; b++) begin
            @(posedge ref_clk_in);
            ev[b] <= 1'b1;
            @(posedge ref_clk_in);
            ev[b] <= 1'b0;
        end
        rd(OFS_IRQ_FLAGS, 8'h3f, "flags set");
        wr(OFS_IRQ_FLAGS, 8'hff);
        rd(OFS_IRQ_FLAGS, 8'h3f, "flags after ones");
        check("irq", {7'h00, irq_out}, 8'h01);
        wr(OFS_IRQ_EN, 8'h10);
        wr(OFS_IRQ_FLAGS, 8'h2f);
        rd(OFS_IRQ_FLAGS, 8'h2f, "short cleared");
        repeat (2) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
        check("irq masked", {7'h00, irq_out}, 8'h00);
        wr(OFS_IRQ_FLAGS, 8'h1f);
        rd(OFS_IRQ_FLAGS, 8'h0f, "uv cleared");
        rd(12'he60, 8'h00, "unmapped");
        wr(OFS_LOCK, 8'h03);
        wr(OFS_LOCK, 8'h01);
        wr(OFS_DIS_OC, prev[0] ^ 8'hff);
        repeat (60) @(posedge ref_clk_in);
        rd(OFS_DIS_OC, prev[0], "locked level");
        complete_run();
    end
    initial begin
        #900us;
        err_total++;
        complete_run();
    end
endmodule

// File: bp_cfg_pkg.sv
// Constants for the battery protection configuration and event register bank
package bp_cfg_pkg;
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFS_DEEP_UV = 12'he5b;
    localparam logic [11:0] OFS_IRQ_EN = 12'he74;
    localparam logic [11:0] OFS_DIS_OC = 12'he70;
    localparam logic [11:0] OFS_CHG_OC = 12'he71;
    localparam logic [11:0] OFS_DIS_HC = 12'he72;
    localparam logic [11:0] OFS_CHG_HC = 12'he73;
    localparam logic [11:0] OFS_IRQ_FLAGS = 12'he75;
    localparam logic [11:0] OFS_LOCK = 12'he76;
    localparam logic [11:0] OFS_STATUS = 12'he77;
    localparam logic [7:0] RST_DEEP_UV = 8'h00;
    localparam logic [7:0] RST_IRQ_EN = 8'h00;
    localparam logic [7:0] RST_IRQ_FLAGS = 8'h00;
    localparam logic [7:0] RST_LEVEL = 8'hf3;
    localparam logic [7:0] MASK_LOW6 = 8'h3f;
    localparam int FLAG_UV = 5;
    localparam int FLAG_SHORT = 4;
    localparam int FLAG_DIS_OC = 3;
    localparam int FLAG_CHG_OC = 2;
    localparam int FLAG_DIS_HC = 1;
    localparam int FLAG_CHG_HC = 0;
    localparam int DLY_LSB = 4;
    localparam int LVL_MSB = 3;
    localparam int LOCK_EN_BIT = 1;
    localparam int LOCK_BIT = 0;
    localparam logic [2:0] LOCK_WINDOW = 3'h4;
    localparam logic [1:0] SLOW_EDGES = 2'h3;
    localparam logic [1:0] CPU_CYCLES = 2'h3;
    // Valid threshold codes, lowest to highest threshold
    localparam int NUM_CODES = 27;
    localparam logic [7:0] CODE_TABLE [NUM_CODES] = '{
        8'hf3, 8'hf4, 8'hf5, 8'hf6, 8'hf7, 8'hf8, 8'hf9, 8'hfa, 8'hfb, 8'hfc, 8'hfd,
        8'h78, 8'h79, 8'h7a, 8'h7b, 8'h7c, 8'h7d, 8'h7e, 8'h7f,
        8'h39, 8'h3a, 8'h3b, 8'h3c, 8'h3d, 8'h3e, 8'h3f, 8'h19};
endpackage

// File: bp_cfg_regs.sv
// Battery protection threshold, deep under-voltage and interrupt register bank
// Summary of operation
// - Threshold register ignores writes until its guard time has passed.
// - Discharge over-current level holds an 8-bit code, discharge table.
// - Charge over-current level holds an 8-bit code, charge table.
// - Discharge high-current level holds an 8-bit code, discharge table.
// - Charge high-current level holds an 8-bit code, charge table.
// - Threshold codes form a non-linear set decoded by table lookup.
// - Deep under-voltage register resets to zero; bits 7:6 read zero.
// - Bits 5:4 pick delay 750, 1000, 1250 or 1500 ms.
// - Bits 3:0 pick one of sixteen detection voltages.
// - Interrupt enable register resets zero, six enables, top bits zero.
// - Under-voltage warning flag sets when 250 ms of delay remain.
// - Under-voltage warning flag stays until software writes zero to it.
// - Short-circuit flag sets when a short-circuit violation is detected.
// - Over-current and high-current flags set on matching violations.
// - Those flags clear only on a written zero; a one leaves them.
// - Flag register bits 7:6 always read zero.
// - Two-step lock sequence write-protects thresholds until hardware reset.
//
// The strobed register port was decided locally.
module bp_cfg_regs
    import bp_cfg_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_in,
    input wire logic [11:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    input wire logic slow_osc_in,
    input wire logic uv_warning_in,
    input wire logic short_event_in,
    input wire logic dis_oc_event_in,
    input wire logic chg_oc_event_in,
    input wire logic dis_hc_event_in,
    input wire logic chg_hc_event_in,
    output logic [7:0] dis_oc_threshold_code_out,
    output logic [7:0] chg_oc_threshold_code_out,
    output logic [7:0] dis_hc_threshold_code_out,
    output logic [7:0] chg_hc_threshold_code_out,
    output logic [4:0] dis_oc_index_out,
    output logic [4:0] chg_oc_index_out,
    output logic [4:0] dis_hc_index_out,
    output logic [4:0] chg_hc_index_out,
    output logic [1:0] undervoltage_delay_sel_out,
    output logic [3:0] undervoltage_level_sel_out,
    output logic irq_out
);
    logic [7:0] level [4];
    logic [7:0] shadow [4];
    logic [4:0] index [4];
    logic [3:0] busy;
    logic [1:0] edges [4];
    logic [1:0] cpu_cnt [4];
    logic [5:0] deep_uv;
    logic [5:0] irq_en;
    logic [5:0] flags;
    logic [5:0] events;
    logic [2:0] osc_sync;
    logic slow_tick;
    logic osc_prev;
    logic locked;
    logic lock_armed;
    logic [2:0] lock_cnt;
    logic [11:0] level_ofs [4];

    assign level_ofs[0] = OFS_DIS_OC;
    assign level_ofs[1] = OFS_CHG_OC;
    assign level_ofs[2] = OFS_DIS_HC;
    assign level_ofs[3] = OFS_CHG_HC;
    assign events = {uv_warning_in, short_event_in, dis_oc_event_in, chg_oc_event_in,
                     dis_hc_event_in, chg_hc_event_in};

    // Slow oscillator is asynchronous: three stages, edge once stages two and three agree
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            osc_sync <= 3'h0;
            osc_prev <= 1'b0;
            slow_tick <= 1'b0;
        end else begin
            osc_sync <= {osc_sync[1:0], slow_osc_in};
            if (osc_sync[2] == osc_sync[1]) begin
                osc_prev <= osc_sync[2];
            end
            slow_tick <= (osc_sync[2] == osc_sync[1]) && osc_sync[2] && !osc_prev;
        end
    end

    // Parameter lock: arm with both bits set, commit within four cycles
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            locked <= 1'b0;
            lock_armed <= 1'b0;
            lock_cnt <= 3'h0;
        end else if (wr_in && addr_in == OFS_LOCK) begin
            if (wdata_in[LOCK_EN_BIT] && wdata_in[LOCK_BIT]) begin
                lock_armed <= 1'b1;
                lock_cnt <= LOCK_WINDOW;
            end else if (lock_armed && !wdata_in[LOCK_EN_BIT] && wdata_in[LOCK_BIT]) begin
                locked <= 1'b1;
                lock_armed <= 1'b0;
            end else begin
                lock_armed <= 1'b0;
            end
        end else if (lock_armed) begin
            lock_cnt <= lock_cnt - 3'h1;
            if (lock_cnt == 3'h1) begin
                lock_armed <= 1'b0;
            end
        end
    end

    generate
        for (genvar i = 0; i < 4; i++) begin : g_level
            logic hit;
            assign hit = wr_in && addr_in == level_ofs[i] && !locked;
            // Guard: level held stable while slow side samples it, then CPU cycles
            always_ff @(posedge ref_clk_in) begin
                if (rst_in) begin
                    level[i] <= RST_LEVEL;
                    shadow[i] <= RST_LEVEL;
                    busy[i] <= 1'b0;
                    edges[i] <= 2'h0;
                    cpu_cnt[i] <= 2'h0;
                end else if (!busy[i]) begin
                    if (hit) begin
                        level[i] <= wdata_in;
                        busy[i] <= 1'b1;
                        edges[i] <= 2'h0;
                        cpu_cnt[i] <= 2'h0;
                    end
                end else if (edges[i] != SLOW_EDGES) begin
                    if (slow_tick) begin
                        edges[i] <= edges[i] + 2'h1;
                        if (edges[i] == 2'h1) begin
                            shadow[i] <= level[i];
                        end
                    end
                end else if (cpu_cnt[i] != CPU_CYCLES - 2'h1) begin
                    cpu_cnt[i] <= cpu_cnt[i] + 2'h1;
                end else begin
                    busy[i] <= 1'b0;
                end
            end
            // Non-linear code set: decode by lookup, invalid codes give index 0
            always_ff @(posedge ref_clk_in) begin
                if (rst_in) begin
                    index[i] <= 5'h0;
                end else begin
                    index[i] <= 5'h0;
                    for (int k = 0; k < NUM_CODES; k++) begin
                        if (shadow[i] == CODE_TABLE[k]) begin
                            index[i] <= 5'(k);
                        end
                    end
                end
            end
            AST_GUARD_HOLDS: assert property (@(posedge ref_clk_in) disable iff (rst_in)
                (busy[i] && wr_in && addr_in == level_ofs[i]) |=> $stable(level[i]))
                else $error("threshold changed during guard time");
            AST_LOCK_BLOCKS: assert property (@(posedge ref_clk_in) disable iff (rst_in)
                locked |=> $stable(level[i]))
                else $error("threshold changed while locked");
            AST_IDLE_WRITE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
                (!busy[i] && hit) |=> level[i] == $past(wdata_in))
                else $error("threshold write not taken");
            AST_BUSY_SETS: assert property (@(posedge ref_clk_in) disable iff (rst_in)
                (!busy[i] && hit) |=> busy[i])
                else $error("guard not started");
            AST_SHADOW_SLOW: assert property (@(posedge ref_clk_in) disable iff (rst_in)
                !slow_tick |=> $stable(shadow[i]))
                else $error("committed code moved off a slow edge");
            AST_INDEX_RANGE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
                index[i] < 5'h1b)
                else $error("index out of table");
            AST_INDEX_FIRST: assert property (@(posedge ref_clk_in) disable iff (rst_in)
                (shadow[i] == CODE_TABLE[0]) |=> index[i] == 5'h00)
                else $error("lowest code index wrong");
            AST_INDEX_LAST: assert property (@(posedge ref_clk_in) disable iff (rst_in)
                (shadow[i] == CODE_TABLE[NUM_CODES - 1]) |=> index[i] == 5'h1a)
                else $error("highest code index wrong");
        end
    endgenerate

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            deep_uv <= RST_DEEP_UV[5:0];
            irq_en <= RST_IRQ_EN[5:0];
        end else if (wr_in) begin
            if (addr_in == OFS_DEEP_UV) begin
                deep_uv <= wdata_in[5:0];
            end
            if (addr_in == OFS_IRQ_EN) begin
                irq_en <= wdata_in[5:0];
            end
        end
    end

    // Set wins over a simultaneous written zero so no event is lost
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            flags <= RST_IRQ_FLAGS[5:0];
        end else if (wr_in && addr_in == OFS_IRQ_FLAGS) begin
            flags <= (flags & wdata_in[5:0]) | events;
        end else begin
            flags <= flags | events;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(flags & irq_en);
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            rdata_out <= 8'h00;
        end else if (rd_in) begin
            unique case (addr_in)
                OFS_DIS_OC: rdata_out <= level[0];
                OFS_CHG_OC: rdata_out <= level[1];
                OFS_DIS_HC: rdata_out <= level[2];
                OFS_CHG_HC: rdata_out <= level[3];
                OFS_DEEP_UV: rdata_out <= {2'b00, deep_uv};
                OFS_IRQ_EN: rdata_out <= {2'b00, irq_en};
                OFS_IRQ_FLAGS: rdata_out <= {2'b00, flags};
                OFS_LOCK: rdata_out <= {6'h00, lock_armed, locked};
                OFS_STATUS: rdata_out <= {4'h0, busy};
                default: rdata_out <= 8'h00;
            endcase
        end else begin
            rdata_out <= 8'h00;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            dis_oc_threshold_code_out <= RST_LEVEL;
            chg_oc_threshold_code_out <= RST_LEVEL;
            dis_hc_threshold_code_out <= RST_LEVEL;
            chg_hc_threshold_code_out <= RST_LEVEL;
            dis_oc_index_out <= 5'h0;
            chg_oc_index_out <= 5'h0;
            dis_hc_index_out <= 5'h0;
            chg_hc_index_out <= 5'h0;
            undervoltage_delay_sel_out <= 2'h0;
            undervoltage_level_sel_out <= 4'h0;
        end else begin
            dis_oc_threshold_code_out <= shadow[0];
            chg_oc_threshold_code_out <= shadow[1];
            dis_hc_threshold_code_out <= shadow[2];
            chg_hc_threshold_code_out <= shadow[3];
            dis_oc_index_out <= index[0];
            chg_oc_index_out <= index[1];
            dis_hc_index_out <= index[2];
            chg_hc_index_out <= index[3];
            undervoltage_delay_sel_out <= deep_uv[5:DLY_LSB];
            undervoltage_level_sel_out <= deep_uv[LVL_MSB:0];
        end
    end

    AST_FLAG_SET: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        events[FLAG_DIS_OC] |=> flags[FLAG_DIS_OC])
        else $error("over-current flag not set");
    AST_SHORT_SET: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        events[FLAG_SHORT] |=> flags[FLAG_SHORT])
        else $error("short flag not set");
    AST_UV_SET: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        events[FLAG_UV] |=> flags[FLAG_UV])
        else $error("warning flag not set");
    AST_ONE_KEEPS: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (wr_in && addr_in == OFS_IRQ_FLAGS) |=> ((flags & $past(flags & wdata_in[5:0])) == $past(flags & wdata_in[5:0])))
        else $error("flag cleared by a written one");
    AST_UV_HOLD: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (flags[FLAG_UV] && !(wr_in && addr_in == OFS_IRQ_FLAGS)) |=> flags[FLAG_UV])
        else $error("warning flag dropped without clear");
    AST_IRQ: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (|(flags & irq_en)) |=> irq_out)
        else $error("interrupt not raised");
    AST_RD_RES: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (rd_in && addr_in == OFS_IRQ_FLAGS) |=> rdata_out[7:6] == 2'b00)
        else $error("reserved flag bits nonzero");
    AST_UV_RES: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (rd_in && addr_in == OFS_DEEP_UV) |=> rdata_out[7:6] == 2'b00)
        else $error("reserved config bits nonzero");
    AST_DLY_OUT: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (wr_in && addr_in == OFS_DEEP_UV) |=> ##1 undervoltage_delay_sel_out == $past(wdata_in[5:4], 2))
        else $error("delay select not forwarded");
    AST_LVL_OUT: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (wr_in && addr_in == OFS_DEEP_UV) |=> ##1 undervoltage_level_sel_out == $past(wdata_in[3:0], 2))
        else $error("level select not forwarded");
    AST_UV_CLEAR: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (wr_in && addr_in == OFS_IRQ_FLAGS && !wdata_in[FLAG_UV] && !events[FLAG_UV]) |=> !flags[FLAG_UV])
        else $error("warning flag not cleared");
    AST_SHORT_CLEAR: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (wr_in && addr_in == OFS_IRQ_FLAGS && !wdata_in[FLAG_SHORT] && !events[FLAG_SHORT]) |=> !flags[FLAG_SHORT])
        else $error("short flag not cleared");
    AST_DOC_CLEAR: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (wr_in && addr_in == OFS_IRQ_FLAGS && !wdata_in[FLAG_DIS_OC] && !events[FLAG_DIS_OC]) |=> !flags[FLAG_DIS_OC])
        else $error("flag not cleared");
    AST_COC_CLEAR: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (wr_in && addr_in == OFS_IRQ_FLAGS && !wdata_in[FLAG_CHG_OC] && !events[FLAG_CHG_OC]) |=> !flags[FLAG_CHG_OC])
        else $error("flag not cleared");
    AST_DHC_CLEAR: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (wr_in && addr_in == OFS_IRQ_FLAGS && !wdata_in[FLAG_DIS_HC] && !events[FLAG_DIS_HC]) |=> !flags[FLAG_DIS_HC])
        else $error("flag not cleared");
    AST_CHC_CLEAR: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (wr_in && addr_in == OFS_IRQ_FLAGS && !wdata_in[FLAG_CHG_HC] && !events[FLAG_CHG_HC]) |=> !flags[FLAG_CHG_HC])
        else $error("flag not cleared");
    AST_COC_SET: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        events[FLAG_CHG_OC] |=> flags[FLAG_CHG_OC])
        else $error("flag not set");
    AST_DHC_SET: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        events[FLAG_DIS_HC] |=> flags[FLAG_DIS_HC])
        else $error("flag not set");
    AST_CHC_SET: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        events[FLAG_CHG_HC] |=> flags[FLAG_CHG_HC])
        else $error("flag not set");
    AST_IRQ_LOW: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        !(|(flags & irq_en)) |=> !irq_out)
        else $error("interrupt without enabled flag");
    AST_EN_RES: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (rd_in && addr_in == OFS_IRQ_EN) |=> rdata_out[7:6] == 2'b00)
        else $error("reserved enable bits nonzero");
    AST_EN_WRITE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (wr_in && addr_in == OFS_IRQ_EN) |=> irq_en == $past(wdata_in[5:0]))
        else $error("enable write lost");
    AST_UV_WRITE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (wr_in && addr_in == OFS_DEEP_UV) |=> deep_uv == $past(wdata_in[5:0]))
        else $error("config write lost");
    AST_FLAG_RD: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (rd_in && addr_in == OFS_IRQ_FLAGS) |=> rdata_out[5:0] == $past(flags))
        else $error("flag readback wrong");
    AST_EN_RD: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (rd_in && addr_in == OFS_IRQ_EN) |=> rdata_out[5:0] == $past(irq_en))
        else $error("enable readback wrong");
    AST_UV_RD: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (rd_in && addr_in == OFS_DEEP_UV) |=> rdata_out[5:0] == $past(deep_uv))
        else $error("config readback wrong");
    AST_RD_IDLE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        !rd_in |=> rdata_out == 8'h00)
        else $error("read data outside its cycle");
    AST_LOCK_STAYS: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        locked |=> locked)
        else $error("lock released before reset");
    AST_ARM_LIMIT: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        lock_cnt <= LOCK_WINDOW)
        else $error("lock window too long");
    AST_TICK_SINGLE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        slow_tick |=> !slow_tick)
        else $error("slow edge counted twice");
    AST_DOC_OUT: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        1'b1 |=> dis_oc_threshold_code_out == $past(shadow[0]))
        else $error("code output stale");
    AST_COC_OUT: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        1'b1 |=> chg_oc_threshold_code_out == $past(shadow[1]))
        else $error("code output stale");
    AST_DHC_OUT: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        1'b1 |=> dis_hc_threshold_code_out == $past(shadow[2]))
        else $error("code output stale");
    AST_CHC_OUT: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        1'b1 |=> chg_hc_threshold_code_out == $past(shadow[3]))
        else $error("code output stale");
endmodule
